// ===== core/estl_builder.sv
// extended self-test log: ring of result entries, index, checksum, byte read port
//
// Behaviour
// - The log is exactly one 512-byte sector.
// - Byte 0 holds revision 01h; byte 1 is reserved.
// - Descriptor index sits in bytes 2 (low) and 3 (high).
// - Eighteen 26-byte slots from byte 4; last slot is bytes 446..471.
// - Slots fill as a ring; result nineteen overwrites slot one.
// - Unused slots read as all zero bytes.
// - Index names newest slot, zero before any test, range 0..18.
// - Entry byte 0 holds the subcommand code of that test.
// - Entry byte 1 holds the execution status at completion.
// - Entry bytes 2..3 hold lifetime hours at completion, low first.
// - Entry byte 4 holds the failure checkpoint byte.
// - Entry bytes 5..10 hold the 48-bit failing address, low first.
// - Only the first failing sector of a test is recorded.
// - Failing address is undefined on pass or non-sector failure.
// - Byte 511 is the negated 8-bit sum of bytes 0..510.
// - Sum of all 512 bytes is zero modulo 256.
// - Log covers both 28-bit and 48-bit addressed self-tests.
`timescale 1ns/100ps
`include "estl_params.svh"
module estl_builder
	import estl_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// self-test engine: test progress
	input wire logic test_start,
	input wire logic fail_hit,
	input wire logic [47:0] fail_lba,
	// self-test engine: completed result
	input wire logic res_valid,
	input wire logic [7:0] res_subcmd,
	input wire logic [7:0] res_status,
	input wire logic [15:0] res_hours,
	input wire logic [7:0] res_chkpt,
	input wire logic res_lba48,
	output logic res_ready,
	// log read port
	input wire logic rd_req,
	input wire logic [8:0] rd_addr,
	output logic rd_ready,
	output logic rd_ack,
	output logic [7:0] rd_data,
	// log state
	output logic [15:0] log_index,
	output logic [4:0] log_count
);
	estl_state_t st;
	estl_state_t next_st;
	logic [7:0] rd_byte;
	logic [7:0] walk_byte;
	logic [7:0] walk_sum;
	logic [4:0] slot;
	logic [47:0] lba_eff;
	estl_entry_t ent_new;

	// one selector serves the host, a second walks the image for the checksum
	estl_byte_sel #(
		.SLOTS(`ESTL_SLOTS),
		.EBITS(`ESTL_ENTRY_BITS)
	) u_rd_sel (
		.idx(st.idx),
		.ents(st.ents),
		.chk(st.chk),
		.addr(rd_addr),
		.data(rd_byte)
	);

	estl_byte_sel #(
		.SLOTS(`ESTL_SLOTS),
		.EBITS(`ESTL_ENTRY_BITS)
	) u_walk_sel (
		.idx(st.idx),
		.ents(st.ents),
		.chk(st.chk),
		.addr(st.walk),
		.data(walk_byte)
	);

	always_comb begin
		next_st = st;
		slot = 5'h00;
		lba_eff = 48'h0;
		ent_new = '0;
		walk_sum = st.acc + walk_byte; // carries dropped
		next_st.rd_ack = 1'b0;

		// first failing sector wins; a new test rearms the capture
		if (test_start) begin
			next_st.fail_seen = 1'b0;
		end
		if (fail_hit && (!st.fail_seen || test_start)) begin
			next_st.fail_seen = 1'b1;
			next_st.fail_lba = fail_lba;
		end

		// reads see the image as it stands; refused while the sum is stale
		if (rd_req && st.ready) begin
			next_st.rd_ack = 1'b1;
			next_st.rd_data = rd_byte;
		end

		case (st.fsm)
			ST_SUM: begin
				// walks bytes 0..510, one per clock
				next_st.acc = walk_sum;
				next_st.walk = st.walk + 9'h001;
				if (st.walk == `ESTL_OFS_LAST_SUMMED) begin
					next_st.chk = 8'h00 - walk_sum;
					next_st.fsm = ST_IDLE;
					next_st.ready = 1'b1;
				end
			end
			ST_IDLE: begin
				if (res_valid && st.ready) begin
					// next slot after the newest, wrapping 18 back to 1
					if (st.idx[4:0] == `ESTL_SLOT_LAST) begin
						slot = 5'h01;
					end else begin
						slot = st.idx[4:0] + 5'h01;
					end
					// address of no meaning unless a sector failed: zero then
					if (st.fail_seen) begin
						lba_eff = st.fail_lba;
					end
					// 28-bit tests keep only their 28 address bits
					if (!res_lba48) begin
						lba_eff = lba_eff & `ESTL_LBA28_MASK;
					end
					ent_new[`ESTL_FLD_SUBCMD +: 8] = res_subcmd;
					ent_new[`ESTL_FLD_STATUS +: 8] = res_status;
					ent_new[`ESTL_FLD_HOURS +: 16] = res_hours;
					ent_new[`ESTL_FLD_CHKPT +: 8] = res_chkpt;
					ent_new[`ESTL_FLD_LBA +: 48] = lba_eff;
					next_st.ents[slot - 5'h01] = ent_new;
					next_st.idx = {11'h000, slot};
					if (st.count != `ESTL_SLOT_LAST) begin
						next_st.count = st.count + 5'h01;
					end
					next_st.fail_seen = 1'b0;
					next_st.fsm = ST_SUM;
					next_st.walk = 9'h000;
					next_st.acc = 8'h00;
					next_st.ready = 1'b0;
				end
			end
			default: begin
				next_st.fsm = ST_SUM;
				next_st.walk = 9'h000;
				next_st.acc = 8'h00;
				next_st.ready = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			// empty log: zero slots, zero index, sum computed after release
			st.fsm <= ST_SUM;
			st.ready <= 1'b0;
			st.walk <= 9'h000;
			st.acc <= 8'h00;
			st.chk <= 8'h00;
			st.idx <= `ESTL_IDX_RESET;
			st.count <= `ESTL_COUNT_RESET;
			st.ents <= '0;
			st.fail_seen <= 1'b0;
			st.fail_lba <= 48'h0;
			st.rd_ack <= 1'b0;
			st.rd_data <= 8'h00;
		end else begin
			st <= next_st;
		end
	end

	// all outputs are fields of the state register
	assign res_ready = st.ready;
	assign rd_ready = st.ready;
	assign rd_ack = st.rd_ack;
	assign rd_data = st.rd_data;
	assign log_index = st.idx;
	assign log_count = st.count;
endmodule // estl_builder

// ===== shared/estl_params.svh
// offsets, field positions, reset values and counts of the extended self-test log sector
`ifndef ESTL_PARAMS_SVH
`define ESTL_PARAMS_SVH

`define ESTL_REVISION 8'h01
`define ESTL_OFS_REV 9'h000
`define ESTL_OFS_RSVD 9'h001
`define ESTL_OFS_IDX_LO 9'h002
`define ESTL_OFS_IDX_HI 9'h003
`define ESTL_OFS_SLOT0 9'h004
`define ESTL_OFS_SLOT1 9'h01E
`define ESTL_OFS_LAST_ENTRY 9'h1F1
`define ESTL_OFS_LAST_SUMMED 9'h1FE
`define ESTL_OFS_SUM 9'h1FF
`define ESTL_SECTOR_BYTES 10'h200
`define ESTL_LOG_SECTORS 1
`define ESTL_ENTRY_BYTES 9'h01A
`define ESTL_ENTRY_USED 9'h00B
`define ESTL_SLOTS 18
`define ESTL_SLOT_LAST 5'h12
`define ESTL_ENTRY_BITS 88
`define ESTL_FLD_SUBCMD 0
`define ESTL_FLD_STATUS 8
`define ESTL_FLD_HOURS 16
`define ESTL_FLD_CHKPT 32
`define ESTL_FLD_LBA 40
`define ESTL_LBA28_MASK 48'h0000_0FFF_FFFF
`define ESTL_IDX_RESET 16'h0000
`define ESTL_COUNT_RESET 5'h00

`endif

// ===== shared/estl_pkg.sv
// types of the extended self-test log builder
package estl_pkg;
`include "estl_params.svh"

	typedef enum logic [0:0] {
		ST_SUM,
		ST_IDLE
	} estl_fsm_t;

	typedef logic [`ESTL_ENTRY_BITS-1:0] estl_entry_t;

	typedef struct packed {
		estl_fsm_t fsm;
		logic ready;
		logic [8:0] walk;
		logic [7:0] acc;
		logic [7:0] chk;
		logic [15:0] idx;
		logic [4:0] count;
		logic [`ESTL_SLOTS-1:0][`ESTL_ENTRY_BITS-1:0] ents;
		logic fail_seen;
		logic [47:0] fail_lba;
		logic rd_ack;
		logic [7:0] rd_data;
	} estl_state_t;
endpackage

// ===== core/estl_byte_sel.sv
// picks one byte of the log sector image by its byte address
`timescale 1ns/100ps
`include "estl_params.svh"
module estl_byte_sel
	import estl_pkg::*;
#(
	parameter int SLOTS = `ESTL_SLOTS,
	parameter int EBITS = `ESTL_ENTRY_BITS
) (
	// sector image
	input wire logic [15:0] idx,
	input wire logic [SLOTS*EBITS-1:0] ents,
	input wire logic [7:0] chk,
	// byte select
	input wire logic [8:0] addr,
	output logic [7:0] data
);
	logic [8:0] rel;
	logic [8:0] slot;
	logic [8:0] off;
	logic [EBITS-1:0] ent;

	always_comb begin
		rel = addr - `ESTL_OFS_SLOT0;
		slot = rel / `ESTL_ENTRY_BYTES;
		off = rel % `ESTL_ENTRY_BYTES;
		ent = ents[slot[4:0]*EBITS +: EBITS];
		data = 8'h00;
		if (addr == `ESTL_OFS_REV) begin
			data = `ESTL_REVISION;
		end else if (addr == `ESTL_OFS_IDX_LO) begin
			data = idx[7:0];
		end else if (addr == `ESTL_OFS_IDX_HI) begin
			data = idx[15:8];
		end else if (addr >= `ESTL_OFS_SLOT0 && addr <= `ESTL_OFS_LAST_ENTRY) begin
			// entry bytes 0..10 in field order, vendor tail zero
			if (off < `ESTL_ENTRY_USED) begin
				data = ent[off[3:0]*8 +: 8];
			end
		end else if (addr == `ESTL_OFS_SUM) begin
			data = chk;
		end
		// reserved byte 1 and bytes 498..510 stay zero
	end
endmodule // estl_byte_sel

// ===== tb/estl_builder_sva.sv
// assertions and covers on the log builder ports
`timescale 1ns/100ps
module estl_builder_sva (
	// clock, reset and handshakes
	input wire logic clk_sys, srst, res_valid, res_ready, rd_req, rd_ready, rd_ack,
	// data and state
	input wire logic [8:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic [15:0] log_index,
	input wire logic [4:0] log_count
);
	wire take = rd_req && rd_ready;
	wire put = res_valid && res_ready;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	read_ack_a: assert property (take |=> rd_ack) else $error("no ack");
	stray_ack_a: assert property (!take |=> !rd_ack) else $error("stray ack");
	rev_byte_a: assert property (take && rd_addr == 9'h000 |=> rd_data == 8'h01)
		else $error("bad revision");
	index_low_a: assert property (take && rd_addr == 9'h002 |=> rd_data == $past(log_index[7:0]))
		else $error("bad index byte");
	tail_zero_a: assert property (take && rd_addr >= 9'h1F2 && rd_addr <= 9'h1FE |=> rd_data == 8'h00)
		else $error("tail not zero");
	index_range_a: assert property (log_index <= 16'h0012 && log_count <= 5'h12)
		else $error("index out of range");
	ring_step_a: assert property (put |=> log_index ==
		($past(log_index) == 16'h0012 ? 16'h0001 : $past(log_index) + 16'h0001)) else $error("bad step");
	walk_busy_a: assert property (put |=> !res_ready [*8]) else $error("ready during walk");
	index_hold_a: assert property (!put |=> $stable(log_index)) else $error("index moved");
	cover property (put && log_index == 16'h0012);
	cover property (take && rd_addr == 9'h1FF);
	cover property (put && log_count == 5'h12);
endmodule // estl_builder_sva

bind estl_builder estl_builder_sva u_sva (.clk_sys, .srst, .res_valid, .res_ready, .rd_req,
	.rd_ready, .rd_ack, .rd_addr, .rd_data, .log_index, .log_count);

// ===== tb/estl_host_model.sv
// host side: reads the whole log sector and sums it
`timescale 1ns/100ps
module estl_host_model (
	// clock and command
	input wire logic clk_sys, go, rd_ready, rd_ack,
	input wire logic [7:0] rd_data,
	// read requests
	output logic rd_req, done,
	output logic [8:0] rd_addr
);
	logic [7:0] img [512];
	logic [7:0] sum;
	initial begin
		rd_req = 1'b0;
		rd_addr = 9'h1FF;
		done = 1'b0;
		forever begin
			@(posedge clk_sys);
			if (!go)
				done = 1'b0;
			else if (!done) begin
				sum = 8'h00;
				for (int a = 0; a < 512; a++) begin
					#1 rd_req = 1'b1;
					rd_addr = a[8:0];
					do @(posedge clk_sys); while (rd_ready !== 1'b1);
					// released address shows garbage, not the last value
					#1 rd_req = 1'b0;
					rd_addr = ~a[8:0];
					@(posedge clk_sys);
					img[a] = rd_data;
					sum = sum + rd_data;
				end
				done = 1'b1;
			end
		end
	end
endmodule // estl_host_model

// ===== tb/tb_estl_builder.sv
// self-checking bench of the extended self-test log builder
`timescale 1ns/100ps
module tb_estl_builder;
	logic clk_sys = 1'b0, srst = 1'b1, test_start = 1'b0, fail_hit = 1'b0, res_valid = 1'b0;
	logic res_lba48 = 1'b0, go = 1'b0, res_ready, rd_req, rd_ready, rd_ack, done;
	logic [47:0] fail_lba = 48'h0;
	logic [7:0] res_subcmd = 8'h00, res_status = 8'h00, res_chkpt = 8'h00, rd_data;
	logic [15:0] res_hours = 16'h0000, log_index;
	logic [8:0] rd_addr;
	logic [4:0] log_count;
	int mismatches = 0, num_checks = 0;
	always #50 clk_sys = ~clk_sys;
	estl_builder DUT (.clk_sys, .srst, .test_start, .fail_hit, .fail_lba, .res_valid, .res_subcmd,
		.res_status, .res_hours, .res_chkpt, .res_lba48, .res_ready, .rd_req, .rd_addr, .rd_ready,
		.rd_ack, .rd_data, .log_index, .log_count);
	estl_host_model host (.clk_sys, .go, .rd_ready, .rd_ack, .rd_data, .rd_req, .done, .rd_addr);
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// odd results are 28-bit tests, so only the low 28 address bits survive
	function automatic logic [7:0] ebyte(int r, int j);
		logic [47:0] v;
		logic [87:0] e;
		v = 48'hA5C3_1234_5600 + 48'(r);
		if (r % 2)
			v = v & 48'h0000_0FFF_FFFF;
		e = {v, 8'(r * 3), 16'h7700 + 16'(r), 8'(r + 8'h40), 8'(r)};
		return (j < 11) ? e[j*8 +: 8] : 8'h00;
	endfunction
	task automatic wait_idle();
		for (int i = 0; i < 600 && res_ready !== 1'b1; i++) @(posedge clk_sys);
		chk(res_ready, 1'b1);
		#1;
	endtask
	task automatic read_sector();
		go = 1'b1;
		for (int i = 0; i < 1100 && done !== 1'b1; i++) @(posedge clk_sys);
		#1 go = 1'b0;
		chk(done, 1'b1);
		chk(host.sum, 16'h0000);
	endtask
	task automatic t_empty();
		read_sector();
		for (int a = 0; a < 512; a++)
			chk(host.img[a], a == 0 ? 8'h01 : a == 511 ? 8'hFF : 8'h00);
	endtask
	// r % 3 failing sectors per test; a second hit must not replace the first
	task automatic add_res(input int r);
		test_start = 1'b1;
		@(posedge clk_sys) #1 test_start = 1'b0;
		fail_hit = (r % 3) != 0;
		for (int k = 0; k < r % 3; k++) begin
			fail_lba = 48'hA5C3_1234_5600 + 48'(r) + 48'(k * 7);
			@(posedge clk_sys) #1;
		end
		fail_hit = 1'b0;
		res_valid = 1'b1;
		res_subcmd = ebyte(r, 0);
		res_status = ebyte(r, 1);
		res_hours = {ebyte(r, 3), ebyte(r, 2)};
		res_chkpt = ebyte(r, 4);
		res_lba48 = !(r % 2);
		@(posedge clk_sys) #1 res_valid = 1'b0;
		chk(log_index, 16'((r - 1) % 18 + 1));
		chk(log_count, r > 18 ? 18 : r);
		wait_idle();
	endtask
	task automatic t_ring();
		for (int r = 1; r <= 19; r++)
			add_res(r);
	endtask
	task automatic t_image();
		read_sector();
		chk(host.img[0], 8'h01);
		chk({host.img[3], host.img[2]}, 16'h0001);
		for (int s = 1; s <= 18; s++)
			for (int j = 0; j < 26; j++)
				if (j < 5 || j > 10 || (s == 1 ? 19 : s) % 3 != 0)
					chk(host.img[4 + 26 * (s - 1) + j], ebyte(s == 1 ? 19 : s, j));
		for (int a = 498; a < 511; a++)
			chk(host.img[a], 8'h00);
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		#1 srst = 1'b0;
		wait_idle();
		t_empty();
		t_ring();
		t_image();
		conclude();
	end
	initial begin
		#3_000_000;
		mismatches++;
		conclude();
	end
endmodule // tb_estl_builder
